// ---- src/spas_top.sv ----
// serial channel: async start-stop and clock-synchronous transfers
`timescale 1ns/10ps
`default_nettype none
module spas_top (
	input  wire logic             clk_i,        // 10 MHz peripheral clock
	input  wire logic             nrst_i,       // async reset, active low
	input  wire spas_pkg::spas_mode_t mode_i,   // serial_mode_reg
	input  wire spas_pkg::spas_ctrl_t ctrl_i,   // serial_control_reg
	output spas_pkg::spas_stat_t  stat_o,       // serial_status_reg
	input  wire logic [7:0]       tx_data_i,    // transmit_byte_reg write data
	input  wire logic             tx_wr_i,      // transmit_byte_reg write strobe
	output logic [7:0]            rx_data_o,    // received_byte_reg
	input  wire logic             rx_rd_i,      // received_byte_reg read strobe
	input  wire logic             err_clr_i,    // clear error flags
	input  wire logic             timer_i,      // reload timer output pulse level
	input  wire logic             sck_i,        // external serial clock pin
	output logic                  sck_o,        // serial clock out (sync master)
	output logic                  sck_oe_n_o,   // sck drive enable, low drives
	input  wire logic             rxd_i,        // serial data in pin
	output logic                  txd_o,        // serial data out pin
	output logic                  rx_irq_o,     // receive interrupt request
	output logic                  tx_irq_o      // transmit interrupt request
);
	// pin synchronisers; the delayed copies feed the edge detectors
	logic rxd, rxd_d, sck_q, sck_d, tmr_q, tmr_d;
	spas_sync #(.RST_LVL(1'b1)) rxd_sync_i (
		.clk_i,
		.nrst_i,
		.d_i   (rxd_i),
		.q_o   (rxd),
		.dly_o (rxd_d)
	);
	spas_sync #(.RST_LVL(1'b0)) sck_sync_i (
		.clk_i,
		.nrst_i,
		.d_i   (sck_i),
		.q_o   (sck_q),
		.dly_o (sck_d)
	);
	spas_sync #(.RST_LVL(1'b0)) tmr_sync_i (
		.clk_i,
		.nrst_i,
		.d_i   (timer_i),
		.q_o   (tmr_q),
		.dly_o (tmr_d)
	);

	// baud generator: rate = max / 2^sel
	logic [15:0] div_cnt;
	wire  [15:0] div_reload = 16'(spas_pkg::DIV_BASE << mode_i.baud_sel) - 16'h1;
	wire         gen_tick   = (div_cnt == 16'h0);
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			div_cnt <= 16'h0;
		else
			div_cnt <= gen_tick ? div_reload : div_cnt - 16'h1;
	end

	wire ext_rise = sck_q & ~sck_d;
	wire tmr_rise = tmr_q & ~tmr_d;
	// one tick per oversample slot (async) or per half bit clock (sync)
	wire tick = (mode_i.clk_src == spas_pkg::CSRC_EXT)   ? ext_rise :
	            (mode_i.clk_src == spas_pkg::CSRC_TIMER) ? tmr_rise :
	                                                       gen_tick;
	wire is_sync  = (mode_i.mode == spas_pkg::MODE_SYNC);
	wire is_multi = (mode_i.mode == spas_pkg::MODE_MULTI);
	wire ext_sync = is_sync && (mode_i.clk_src == spas_pkg::CSRC_EXT);
	// seven bits only in async normal mode
	wire [3:0] nbits = (!ctrl_i.len8 && mode_i.mode == spas_pkg::MODE_ASYNC) ?
	                   spas_pkg::BITS_7 : spas_pkg::BITS_8;
	wire par_on = ctrl_i.parity_en && !is_multi && !is_sync;
	wire xbit   = is_multi | par_on;

	// ---------------- transmitter ----------------
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP} spas_txst_t;
	spas_txst_t tx_st;
	logic [7:0] tx_hold, tx_sh;
	logic       tx_hold_full, tx_par, tx_xv;
	logic [3:0] tx_ovs, tx_cnt;
	logic       sclk_ph;
	// sync mode: a "bit" is two ticks (low then high phase); async: sixteen
	wire tx_bit_end = is_sync ? (tick && sclk_ph) : (tick && tx_ovs == spas_pkg::OVS_LAST);
	wire tx_load    = (tx_st == TX_IDLE) && tx_hold_full && ctrl_i.tx_en;
	wire tx_done    = (tx_st == TX_STOP && tx_bit_end) ||
	                  (is_sync && tx_st == TX_DATA && tx_bit_end && tx_cnt == nbits - 4'h1);
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_st        <= TX_IDLE;
			tx_hold      <= 8'h0;
			tx_hold_full <= 1'b0;
			tx_sh        <= 8'h0;
			tx_par       <= 1'b0;
			tx_xv        <= 1'b0;
			tx_ovs       <= 4'h0;
			tx_cnt       <= 4'h0;
			sclk_ph      <= 1'b0;
			txd_o        <= 1'b1;
			tx_irq_o     <= 1'b0;
		end else begin
			tx_irq_o <= tx_done && ctrl_i.tx_int_en;
			if (tx_wr_i)
				tx_hold_full <= 1'b1;
			else if (tx_load)
				tx_hold_full <= 1'b0;
			if (tx_wr_i)
				tx_hold <= tx_data_i;
			if (tick)
				tx_ovs <= (tx_st == TX_IDLE) ? 4'h0 : tx_ovs + 4'h1;
			if (tick && tx_st != TX_IDLE)
				sclk_ph <= ~sclk_ph;
			case (tx_st)
				TX_IDLE: begin
					sclk_ph <= 1'b0;
					if (tx_load) begin
						tx_sh  <= tx_hold;
						tx_par <= ^tx_hold[6:0] ^ (ctrl_i.len8 & tx_hold[7]) ^ ctrl_i.parity_odd;
						tx_xv  <= is_multi ? ctrl_i.addr_bit : 1'b0;
						tx_cnt <= 4'h0;
						tx_st  <= is_sync ? TX_DATA : TX_START;
						txd_o  <= is_sync ? tx_hold[0] : 1'b0;
					end
				end
				TX_START: if (tx_bit_end) begin
					tx_st <= TX_DATA;
					txd_o <= tx_sh[0];
				end
				TX_DATA: if (tx_bit_end) begin
					tx_sh  <= {1'b1, tx_sh[7:1]};
					tx_cnt <= tx_cnt + 4'h1;
					if (tx_cnt == nbits - 4'h1) begin
						tx_st <= is_sync ? TX_IDLE : (xbit ? TX_EXTRA : TX_STOP);
						txd_o <= is_sync ? 1'b1 : (xbit ? (is_multi ? tx_xv : tx_par) : 1'b1);
					end else
						txd_o <= tx_sh[1];
				end
				TX_EXTRA: if (tx_bit_end) begin
					tx_st <= TX_STOP;
					txd_o <= 1'b1;
				end
				default: if (tx_bit_end)
					tx_st <= TX_IDLE;
			endcase
		end
	end
	// master drives its clock in sync mode unless clocked externally
	always_comb begin
		sck_o      = (tx_st == TX_DATA) ? sclk_ph : 1'b1;
		sck_oe_n_o = !(is_sync && !ext_sync);
	end

	// ---------------- receiver ----------------
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} spas_rxst_t;
	spas_rxst_t rx_st;
	logic [7:0] rx_sh;
	logic [3:0] rx_ovs, rx_cnt;
	logic       rx_xv, rx_full, ovr, fre, pre, rx_done_q;
	// sync receive samples on rising serial clock: own clock or external edge
	wire sync_smp = is_sync && (ext_sync ? ext_rise : (tick && !sclk_ph && tx_st == TX_DATA));
	wire rx_smp   = is_sync ? sync_smp : (tick && rx_ovs == spas_pkg::OVS_MID);
	wire [7:0] rx_byte = (nbits == spas_pkg::BITS_7) ? {1'b0, rx_sh[7:1]} : rx_sh;
	wire rx_fin   = rx_smp && ((rx_st == RX_STOP) ||
	                (is_sync && rx_st == RX_DATA && rx_cnt == spas_pkg::BITS_8 - 4'h1));
	wire par_bad  = par_on && ((^rx_byte) ^ rx_xv ^ ctrl_i.parity_odd);
	wire stop_bad = !is_sync && !rxd;
	wire ovr_set  = rx_fin && rx_full && !rx_rd_i;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_st     <= RX_IDLE;
			rx_sh     <= 8'h0;
			rx_ovs    <= 4'h0;
			rx_cnt    <= 4'h0;
			rx_xv     <= 1'b0;
			rx_full   <= 1'b0;
			rx_data_o <= 8'h0;
			rx_done_q <= 1'b0;
		end else begin
			rx_done_q <= rx_fin;
			if (tick)
				rx_ovs <= (rx_st == RX_IDLE) ? 4'h0 : rx_ovs + 4'h1;
			// set beats clear for every flag
			if (rx_fin && !ovr_set)
				rx_full <= 1'b1;
			else if (rx_rd_i)
				rx_full <= 1'b0;
			if (rx_fin && !ovr_set)
				rx_data_o <= is_sync ? rx_sh : rx_byte;
			case (rx_st)
				RX_IDLE: if (ctrl_i.rx_en) begin
					if (is_sync && sync_smp) begin
						rx_sh  <= {rxd, rx_sh[7:1]};
						rx_cnt <= 4'h1;
						rx_st  <= RX_DATA;
					// falling edge only: a held-low line after a bad stop is no new start
					end else if (!is_sync && rxd_d && !rxd) begin
						rx_cnt <= 4'h0;
						rx_st  <= RX_START;
					end
				end
				RX_START: if (rx_smp)
					rx_st <= rxd ? RX_IDLE : RX_DATA;    // glitch: back to idle
				RX_DATA: if (rx_smp) begin
					rx_sh  <= {rxd, rx_sh[7:1]};
					rx_cnt <= rx_cnt + 4'h1;
					if (is_sync && rx_cnt == spas_pkg::BITS_8 - 4'h1)
						rx_st <= RX_IDLE;
					else if (!is_sync && rx_cnt == nbits - 4'h1)
						rx_st <= xbit ? RX_EXTRA : RX_STOP;
				end
				RX_EXTRA: if (rx_smp) begin
					rx_xv <= rxd;
					rx_st <= RX_STOP;
				end
				default: if (rx_smp)
					rx_st <= RX_IDLE;    // only the first stop bit is looked at
			endcase
		end
	end
	// sticky error flags
	spas_flag ovr_flag_i (
		.clk_i,
		.nrst_i,
		.set_i  (ovr_set),
		.clr_i  (err_clr_i),
		.flag_o (ovr)
	);
	spas_flag fre_flag_i (
		.clk_i,
		.nrst_i,
		.set_i  (rx_fin && stop_bad),
		.clr_i  (err_clr_i),
		.flag_o (fre)
	);
	spas_flag pre_flag_i (
		.clk_i,
		.nrst_i,
		.set_i  (rx_fin && par_bad),
		.clr_i  (err_clr_i),
		.flag_o (pre)
	);
	// a seven-bit frame shifts one short; the assembled byte is re-aligned above
	always_comb begin
		rx_irq_o           = ctrl_i.rx_int_en && (rx_done_q || ovr || fre || pre);
		stat_o.parity_err  = pre;
		stat_o.overrun_err = ovr;
		stat_o.frame_err   = fre;
		stat_o.rx_full     = rx_full;
		stat_o.tx_empty    = !tx_hold_full;
	end
endmodule

// two-flop synchroniser plus one delayed copy for edge detection
module spas_sync #(
	parameter logic RST_LVL = 1'b0
) (
	input  wire logic clk_i,  // peripheral clock
	input  wire logic nrst_i, // async reset, active low
	input  wire logic d_i,    // pin level
	output logic      q_o,    // synchronised level
	output logic      dly_o   // q_o one cycle later
);
	logic meta;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta  <= RST_LVL;
			q_o   <= RST_LVL;
			dly_o <= RST_LVL;
		end else begin
			meta  <= d_i;
			q_o   <= meta;
			dly_o <= q_o;
		end
	end
endmodule

// sticky error flag; a set in the clearing cycle wins
module spas_flag (
	input  wire logic clk_i,  // peripheral clock
	input  wire logic nrst_i, // async reset, active low
	input  wire logic set_i,  // error event
	input  wire logic clr_i,  // software clear
	output logic      flag_o  // sticky flag
);
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			flag_o <= 1'b0;
		else
			flag_o <= set_i | (flag_o & ~clr_i);
	end
endmodule
`default_nettype wire

// ---- src/spas_pkg.sv ----
// package for the async/sync serial channel: constants and register carriers
package spas_pkg;
	localparam int unsigned CLK_HZ       = 10_000_000;
	localparam int unsigned BAUD_HZ_MAX  = 625_000;
	// divider reload per baud select; count is ticks of 16x oversampling
	localparam int unsigned DIV_BASE     = CLK_HZ / (BAUD_HZ_MAX * 16);
	localparam logic [2:0]  MODE_ASYNC   = 3'h0;
	localparam logic [2:0]  MODE_MULTI   = 3'h1;
	localparam logic [2:0]  MODE_SYNC    = 3'h2;
	localparam logic [1:0]  CSRC_BAUD    = 2'h0;
	localparam logic [1:0]  CSRC_TIMER   = 2'h1;
	localparam logic [1:0]  CSRC_EXT     = 2'h2;
	localparam logic [3:0]  OVS_LAST     = 4'hF;
	localparam logic [3:0]  OVS_MID      = 4'h7;
	localparam logic [3:0]  BITS_8       = 4'h8;
	localparam logic [3:0]  BITS_7       = 4'h7;
	localparam logic [7:0]  IDLE_BYTE    = 8'hFF;

	// serial_mode_reg
	typedef struct packed {
		logic [2:0] mode;      // 0 async normal, 1 multiprocessor, 2 sync
		logic [1:0] clk_src;   // baud generator, reload timer, external
		logic [2:0] baud_sel;  // one of eight generator rates
	} spas_mode_t;

	// serial_control_reg
	typedef struct packed {
		logic parity_en;
		logic parity_odd;
		logic len8;            // 0 selects seven bits (async normal only)
		logic addr_bit;        // address/data mark in multiprocessor mode
		logic rx_en;
		logic tx_en;
		logic rx_int_en;
		logic tx_int_en;
	} spas_ctrl_t;

	// serial_status_reg
	typedef struct packed {
		logic parity_err;
		logic overrun_err;
		logic frame_err;
		logic rx_full;
		logic tx_empty;
	} spas_stat_t;
endpackage

// ---- bench/spas_top_asserts.sv ----
// concurrent checks on the serial channel top ports
`timescale 1ns/10ps
`default_nettype none
module spas_top_asserts (
	input wire logic                 clk_i,      // clock
	input wire logic                 nrst_i,     // reset
	input wire spas_pkg::spas_mode_t mode_i,     // mode
	input wire spas_pkg::spas_ctrl_t ctrl_i,     // control
	input wire spas_pkg::spas_stat_t stat_o,     // status
	input wire logic                 tx_wr_i,    // tx write
	input wire logic                 rx_rd_i,    // rx read
	input wire logic                 err_clr_i,  // flag clear
	input wire logic [7:0]           rx_data_o,  // rx byte
	input wire logic                 sck_oe_n_o, // clock drive
	input wire logic                 txd_o,      // line out
	input wire logic                 rx_irq_o,   // rx request
	input wire logic                 tx_irq_o    // tx request
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire logic err = stat_o.parity_err | stat_o.overrun_err | stat_o.frame_err;
	// fastest generator rate in a framed mode: every bit lasts 16 cycles
	wire logic gen0 = mode_i.mode != spas_pkg::MODE_SYNC && mode_i[4:0] == 5'h00;
	tx_pulse_a: assert property (tx_irq_o |=> !tx_irq_o) else $error("tx irq long");
	rx_err_irq_a: assert property ((ctrl_i.rx_int_en && err) [*2] |-> rx_irq_o)
		else $error("rx irq missing");
	rx_mask_a: assert property ((!ctrl_i.rx_int_en) [*2] |-> !rx_irq_o)
		else $error("rx irq unmasked");
	bit_len_a: assert property ($fell(txd_o) && gen0 |-> (!txd_o) [*8] ##1 (!txd_o) [*8])
		else $error("bit short");
	tx_hold_a: assert property (tx_wr_i |=> !stat_o.tx_empty) else $error("hold empty");
	rx_keep_a: assert property (stat_o.rx_full && !rx_rd_i |=> $stable(rx_data_o))
		else $error("rx byte moved");
	err_keep_a: assert property (stat_o.frame_err && !err_clr_i |=> stat_o.frame_err)
		else $error("flag lost");
	sck_async_a: assert property ((mode_i.mode != spas_pkg::MODE_SYNC) [*2] |-> sck_oe_n_o)
		else $error("sck driven");
	cover property ($rose(stat_o.overrun_err));
	cover property ($rose(stat_o.parity_err));
	cover property (tx_irq_o);
endmodule
bind spas_top spas_top_asserts spas_top_asserts_i (.clk_i, .nrst_i, .mode_i, .ctrl_i, .stat_o,
	.tx_wr_i, .rx_rd_i, .err_clr_i, .rx_data_o, .sck_oe_n_o, .txd_o, .rx_irq_o, .tx_irq_o);
`default_nettype wire

// ---- bench/spas_peer.sv ----
// far-side serial peer: frames onto rxd, captures frames from txd
`timescale 1ns/10ps
`default_nettype none
module spas_peer (
	input  wire logic clk_i, // bench clock
	input  wire logic txd_i, // device line out
	output var logic  rxd_o  // device line in
);
	initial rxd_o = 1'b1; // line rests at mark
	task automatic send(input logic [9:0] f, input int nb, input int bc, input logic st);
		@(negedge clk_i);
		rxd_o = 1'b0;
		repeat (bc) @(negedge clk_i);
		for (int i = 0; i < nb; i++) begin
			rxd_o = f[i];
			repeat (bc) @(negedge clk_i);
		end
		rxd_o = st;
		repeat (2 * bc) @(negedge clk_i);
		rxd_o = 1'b1;
	endtask
	// mid-bit sampling from the start edge; n counts the stop bit
	task automatic grab(input int n, input int bc, output logic [9:0] d);
		d = 10'h000;
		@(negedge txd_i);
		repeat (bc / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			repeat (bc) @(posedge clk_i);
			d[i] = txd_i;
		end
	endtask
endmodule
`default_nettype wire

// ---- bench/spas_top_tb.sv ----
// self-checking bench: duplex frames, clock sources, error flags
`timescale 1ns/10ps
`default_nettype none
module spas_top_tb;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] mode = 8'h00, ctrl = 8'h2F, tx_data = 8'h00;
	logic [2:0] stb = 3'h0;
	logic tick = 1'b0, tick_run = 1'b0;
	spas_pkg::spas_stat_t stat;
	logic [7:0] rx_data;
	logic sck_oe_n, rxd, txd, rx_irq, tx_irq;
	int miscompares = 0, total_checks = 0, cyc = 0, tx_irqs = 0;
	always #50 clk_i = ~clk_i;
	always @(negedge clk_i) if (tx_irq === 1'b1) tx_irqs++;
	always @(negedge clk_i) tick <= tick_run & ~tick;
	spas_top spas_top_i (.clk_i, .nrst_i, .mode_i(mode), .ctrl_i(ctrl), .stat_o(stat),
		.tx_data_i(tx_data), .tx_wr_i(stb[2]), .rx_data_o(rx_data), .rx_rd_i(stb[1]),
		.err_clr_i(stb[0]), .timer_i(tick), .sck_i(tick), .sck_o(), .sck_oe_n_o(sck_oe_n),
		.rxd_i(rxd), .txd_o(txd), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
	spas_peer spas_peer_i (.clk_i, .txd_i(txd), .rxd_o(rxd));
	task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// write, read, clear as one-cycle pulses
	task automatic pulse(input logic [2:0] s);
		@(negedge clk_i);
		stb = s;
		@(negedge clk_i);
		stb = 3'h0;
	endtask
	// two extra edges so a registered irq has landed
	task automatic rx_wait(input logic [4:0] m);
		for (int n = 0; n < 99 && (stat & m) == 5'h00; n++) @(posedge clk_i);
		repeat (2) @(negedge clk_i);
	endtask
	task automatic xfer(input logic [7:0] m, input logic [7:0] c, input int bc, input int n,
		input logic [9:0] f);
		logic [9:0] d;
		mode = m;
		ctrl = c;
		tx_data = f[7:0];
		fork
			pulse(3'h4);
			spas_peer_i.grab(n, bc, d);
			spas_peer_i.send(f, n - 1, bc, 1'b1);
		join
		rx_wait(5'h02);
		chk("tx frame", f, d);
		chk("rx byte", {2'h0, f[7:0] & {c[5], 7'h7F}}, {2'h0, rx_data & {c[5], 7'h7F}});
		chk("rx errs", 10'h000, {7'h00, stat[4:2]});
		pulse(3'h2);
	endtask
	task automatic bad(input logic [7:0] c, input logic [9:0] f, input int nb, input logic st,
		input logic [4:0] m);
		ctrl = c;
		spas_peer_i.send(f, nb, 16, st);
		rx_wait(m);
		chk("err flag", {5'h00, m}, {5'h00, stat & m});
		chk("rx irq", {9'h000, c[1]}, {9'h000, rx_irq});
		pulse(3'h3);
		chk("cleared", 10'h001, {5'h00, stat});
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// slowest rate alone takes about 23k cycles, the whole run about 50k
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 70000) begin
			miscompares++;
			report_and_stop();
		end
	end
	initial begin
		repeat (20) @(negedge clk_i);
		chk("reset", 10'h021, {4'h0, txd, stat});
		nrst_i = 1'b1;
		for (int b = 0; b < 8; b++) xfer(b[7:0], 8'h2F, 16 << b, 9, {2'h1, 8'hA5 ^ b[7:0]});
		tick_run = 1'b1;
		xfer(8'h08, 8'h2F, 32, 9, 10'h15A);
		xfer(8'h10, 8'h2F, 32, 9, 10'h1C3);
		tick_run = 1'b0;
		xfer(8'h20, 8'hBF, 16, 10, 10'h333);
		xfer(8'h00, 8'h0F, 16, 8, 10'h0D5);
		xfer(8'h00, 8'hAF, 16, 10, 10'h3B5);
		bad(8'h2D, 10'h055, 8, 1'b0, 5'h04);
		spas_peer_i.send(10'h011, 8, 16, 1'b1);
		bad(8'h2F, 10'h022, 8, 1'b1, 5'h08);
		chk("kept byte", 10'h011, {2'h0, rx_data});
		bad(8'hAF, 10'h0B5, 9, 1'b1, 5'h10);
		mode = 8'h40;
		repeat (4) @(negedge clk_i);
		chk("sck drive", 10'h000, {9'h000, sck_oe_n});
		chk("tx irqs", 10'h00D, tx_irqs[9:0]);
		report_and_stop();
	end
endmodule
`default_nettype wire
